/* bench/hv_supervisor_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// self-checking bench: register bus from here, panel side from the partner model
module hv_supervisor_tb
  import hv_pkg::*;
;
  logic clk, rst, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
  logic [31:0] awa, wd, ara, rd, got;
  logic [1:0] br, rr, resp;
  logic lv, dis, knob, arc, giga, micro, alarm_q;
  logic [1:0] btn;
  logic mod_ok = 1'b1, ovf = 1'b0, ocf = 1'b0, thf = 1'b0;
  logic [16:0] mv, limv, vdisp;
  logic [15:0] cdisp, rdisp;
  logic blank, errs, hv, flash, idle, rdy, ovl, ocl, thl, arcl, vll, cll, meg, gig, ma, ua, alarm;
  int n_errors = 0, num_checks = 0, beeps = 0, b0;
  // one row per display setting, with the readouts it should give
  typedef struct packed {logic l, g, m; logic [16:0] lim, ev; logic [15:0] ec;
    logic eb, evl;} row_type;
  row_type rows [4] = '{'{1'b0, 1'b0, 1'b0, 17'h1F000, 17'h00010, 16'h1234, 1'b0, 1'b0},
    '{1'b1, 1'b1, 1'b0, 17'h1F000, 17'h1F000, 16'h0800, 1'b1, 1'b0},
    '{1'b0, 1'b0, 1'b1, 17'h00010, 17'h00010, 16'h1234, 1'b0, 1'b1},
    '{1'b1, 1'b1, 1'b1, 17'h00010, 17'h00010, 16'h0800, 1'b1, 1'b1}};
  panel_model pm (.ref_clk_i(clk), .lv_o(lv), .btn_o(btn), .dis_o(dis), .knob_o(knob), .arc_o(arc),
    .giga_o(giga), .micro_o(micro), .volts_o(mv), .limv_o(limv));
  hv_supervisor #(.WDOG_CYC_P(64), .BEEP_CYC_P(4)) dut (.ref_clk_i(clk), .rst_i(rst),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .limit_view_i(lv), .enable_buttons_i(btn), .disable_switch_i(dis),
    .volt_knob_min_i(knob), .module_ident_ok_i(mod_ok), .overvolt_fault_i(ovf),
    .overcur_fault_i(ocf), .thermal_fault_i(thf), .load_arc_detect_i(arc), .meas_volts_i(mv),
    .meas_curr_i(16'h1234), .meas_res_i(16'h0ABC), .limit_volts_i(limv), .limit_curr_i(16'h0800),
    .res_giga_i(giga), .curr_micro_i(micro), .volt_disp_o(vdisp), .curr_disp_o(cdisp),
    .res_disp_o(rdisp), .res_blank_o(blank), .res_err_show_o(errs), .hv_enable_o(hv),
    .hazard_flasher_o(flash), .supply_idle_lamp_o(idle), .command_ready_lamp_o(rdy),
    .overvolt_lamp_o(ovl), .overcur_lamp_o(ocl), .thermal_lamp_o(thl), .load_arc_lamp_o(arcl),
    .volt_limit_lamp_o(vll), .curr_limit_lamp_o(cll), .megohm_lamp_o(meg), .gigohm_lamp_o(gig),
    .milliamp_lamp_o(ma), .microamp_lamp_o(ua), .alarm_o(alarm));
  // clock at 200 MHz
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // count beeps by rising edges of the alarm, sampled off the active edge
  always @(negedge clk)
  begin
    alarm_q <= alarm;
    if (alarm === 1'b1 && alarm_q !== 1'b1) beeps <= beeps + 1;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // settle: let n edges pass, then look between edges
  task step(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // write: address and data offered together, each released after the edge that takes it
  task axw(input logic [31:0] a, d);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    do @(negedge clk); while (bv !== 1'b1);
    resp = br;
    @(posedge clk);
    bre <= 1'b0;
  endtask
  // read: hold the request until taken, rready until the answer
  task axr(input logic [31:0] a);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do @(negedge clk); while (arr !== 1'b1);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
    got = rd;
    resp = rr;
    @(posedge clk);
    rre <= 1'b0;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // a hang is cut off long after the sequence should have ended
  initial
  begin
    #200000;
    n_errors++;
    end_of_test;
  end
  initial
  begin
    {awv, wv, bre, arv, rre} = '0;
    {awa, wd, ara} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    step(1);
    chk({hv, idle, cll, rdy}, 4'b0110);
    axr(`ADDR_STATUS);
    chk(got, 32'h0000_0001);
    // failing self-check code locks the panel and shows its code
    axw(`ADDR_SELFTEST, 32'h0000_0105);
    step(6);
    chk({errs, rdy, rdisp}, {2'b10, 16'h0005});
    axw(`ADDR_SELFTEST, 32'h0000_0100);
    step(6);
    axr(`ADDR_STATUS);
    chk(got, 32'h0000_0004);
    chk(rdy, 1'b1);
    axr(32'h0000_0020);
    chk(resp, `RESP_SLVERR);
    $display("test reset and self-check done");
    foreach (rows[i])
    begin
      pm.view(rows[i].l, rows[i].g, rows[i].m, rows[i].lim);
      step(6);
      chk(vdisp, rows[i].ev);
      chk({cdisp, blank}, {rows[i].ec, rows[i].eb});
      chk({gig, meg, ua, ma}, {giga, ~giga, micro, ~micro});
      chk({vll, cll}, {rows[i].evl, ~rows[i].evl});
    end
    pm.view(1'b0, 1'b0, 1'b0, 17'h1F000);
    $display("test display table done");
    // refused starts: one button, knob off minimum, disable held with both
    pm.push(2'b01, 1'b1, 1'b0);
    step(4);
    chk(hv, 1'b0);
    pm.push(2'b11, 1'b0, 1'b0);
    step(4);
    chk(hv, 1'b0);
    pm.push(2'b11, 1'b1, 1'b1);
    step(4);
    chk(hv, 1'b0);
    b0 = beeps;
    pm.push(2'b11, 1'b1, 1'b0);
    step(4);
    chk({hv, flash, idle, rdy}, 4'b1100);
    step(10);
    chk(beeps - b0, 1);
    pm.push(2'b00, 1'b1, 1'b1);
    step(4);
    chk(hv, 1'b0);
    step(6);
    chk(rdy, 1'b1);
    $display("test enable and disable done");
    // refreshes keep the supply up; silence lets the watchdog drop it
    pm.push(2'b11, 1'b1, 1'b0);
    repeat (3)
    begin
      step(40);
      axw(`ADDR_CTRL, 32'h0000_0001);
    end
    chk(hv, 1'b1);
    step(70);
    chk(hv, 1'b0);
    step(6);
    $display("test watchdog done");
    // arc while on: discharge shows live volts, then locks with the captured value
    pm.push(2'b11, 1'b1, 1'b0);
    pm.sense(17'h00100, 1'b0);
    step(3);
    b0 = beeps;
    pm.sense(17'h00100, 1'b1);
    step(6);
    chk({hv, arcl, flash, vdisp}, {3'b011, 17'h00100});
    pm.sense(17'h00050, 1'b1);
    step(4);
    chk({rdy, vdisp}, {1'b0, 17'h00050});
    pm.sense(17'h00010, 1'b0);
    step(40);
    chk({errs, rdisp}, {1'b1, 16'h0008});
    chk(vdisp, 17'h00100);
    chk(beeps - b0, 4);
    pm.push(2'b11, 1'b1, 1'b0);
    step(4);
    chk({hv, rdy, errs}, 3'b001);
    $display("test arc lockout done");
    // power cycle: missing module shows code one, then thermal with overvoltage locks
    @(posedge clk);
    rst <= 1'b1;
    mod_ok <= 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    step(1);
    axw(`ADDR_SELFTEST, 32'h0000_0100);
    step(6);
    chk({errs, rdisp}, {1'b1, 16'h0001});
    @(posedge clk) mod_ok <= 1'b1;
    step(8);
    chk(rdy, 1'b1);
    b0 = beeps;
    @(posedge clk) {thf, ovf} <= 2'b11;
    step(6);
    chk({hv, thl, ovl, ocl, errs, rdisp}, {5'b01101, 16'h0002});
    axr(`ADDR_STATUS);
    chk(got, 32'h0000_1220);
    step(20);
    chk(beeps - b0, 2);
    $display("test power cycle and thermal trip done");
    end_of_test;
  end
endmodule
`default_nettype wire

/* bench/panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side of the panel: operator controls, range selects and specimen sensors
module panel_model
(
  input wire logic ref_clk_i,
  output var logic lv_o,
  output var logic [1:0] btn_o,
  output var logic dis_o,
  output var logic knob_o,
  output var logic arc_o,
  output var logic giga_o,
  output var logic micro_o,
  output var logic [16:0] volts_o,
  output var logic [16:0] limv_o
);
  // quiet panel and a specimen sitting below the safe level
  initial
  begin
    {lv_o, btn_o, dis_o, knob_o, arc_o, giga_o, micro_o} = '0;
    volts_o = 17'h00010;
    limv_o = 17'h1F000;
  end
  // buttons go down in one cycle and come up together, so each push is one request
  task push(input logic [1:0] b, input logic k, input logic d);
    @(posedge ref_clk_i);
    btn_o <= b;
    knob_o <= k;
    dis_o <= d;
    repeat (8) @(posedge ref_clk_i);
    btn_o <= 2'b00;
    dis_o <= 1'b0;
  endtask
  // specimen voltage and arc sensor
  task sense(input logic [16:0] v, input logic a);
    @(posedge ref_clk_i);
    volts_o <= v;
    arc_o <= a;
  endtask
  // display mode, range selects and voltage limit knob
  task view(input logic l, g, m, input logic [16:0] lim);
    @(posedge ref_clk_i);
    lv_o <= l;
    giga_o <= g;
    micro_o <= m;
    limv_o <= lim;
  endtask
endmodule
`default_nettype wire

/* hdl/beep_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// alarm tone sequencer: plays queued beeps, equal on and off times
module beep_gen
  import hv_pkg::*;
#(
  parameter int unsigned BEEP_CYC_P = `BEEP_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  beep_if.gen bus
);
  beep_regs_type cur_reg;
  beep_regs_type cur_next;

  // phase timer, then beep or gap; requests queue onto the count
  always_comb
  begin
    cur_next = cur_reg;
    if (cur_reg.cnt != 32'h0000_0000)
      cur_next.cnt = cur_reg.cnt - 32'h0000_0001;
    else if (cur_reg.on)
    begin
      // beep ended, a gap of equal length follows
      cur_next.on = 1'b0;
      cur_next.left = cur_reg.left - 3'h1;
      cur_next.cnt = 32'(BEEP_CYC_P - 1);
    end
    else if (cur_reg.left != 3'h0)
    begin
      cur_next.on = 1'b1;
      cur_next.cnt = 32'(BEEP_CYC_P - 1);
    end
    // queue saturates at 7 only above 5; from 5 a request of 3 wraps it to zero
    if (bus.req)
      cur_next.left = (cur_next.left > 3'h5) ? 3'h7 : cur_next.left + {1'b0, bus.count};
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cur_reg <= '0;
    else
      cur_reg <= cur_next;
  end

  assign bus.sound = cur_reg.on;

  chk_beep_starts: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (bus.req && bus.count != 2'h0 && cur_reg.left == 3'h0 && !cur_reg.on
     && cur_reg.cnt == 32'h0000_0000) |-> ##2 bus.sound)
    else $error("alarm did not start after request");
endmodule
`default_nettype wire

/* hdl/beep_if.sv */
`timescale 1ns/1ps
`default_nettype none
// alarm request path between supervisor and tone generator
interface beep_if;
  logic req;
  logic [1:0] count;
  logic sound;
  modport ctrl (output req, output count, input sound);
  modport gen (input req, input count, output sound);
endinterface
`default_nettype wire

/* hdl/hv_defs.svh */
`ifndef HV_DEFS_SVH
`define HV_DEFS_SVH
// clock rate and timing figures
`define CLK_MHZ 200
`define WDOG_MS 2000
`define WDOG_CYC (`WDOG_MS * `CLK_MHZ * 1000)
`define BEEP_MS 100
`define BEEP_CYC (`BEEP_MS * `CLK_MHZ * 1000)
// readout widths (volts, current counts, resistance counts) and synchronised pin count
`define VOLT_W 17
`define CURR_W 16
`define RES_W 16
`define SYNC_W 10
// safe specimen level in volts
`define SAFE_VOLTS 17'h00028
// error codes shown on the resistance readout
`define ERR_NONE 4'h0
`define ERR_MOD_UNID 4'h1
`define ERR_THERMAL 4'h2
`define ERR_OVERVOLT 4'h3
`define ERR_OVERCUR 4'h4
`define ERR_LOAD_ARC 4'h8
`define CPU_CODE_MIN 3'h5
// number of alarm beeps per event
`define BEEPS_FAULT 2'h2
`define BEEPS_ENABLE_BUTTONS 2'h1
// register byte addresses
`define ADDR_CTRL 32'h0000_0000
`define ADDR_SELFTEST 32'h0000_0004
`define ADDR_STATUS 32'h0000_0008
`define ADDR_ARC_VOLTS 32'h0000_000C
// field positions and reset values
`define CTRL_KICK_BIT 0
`define SELF_DONE_BIT 8
`define SELFTEST_RST 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* hdl/hv_pkg.sv */
`default_nettype none
package hv_pkg;
`include "hv_defs.svh"

  // supervisor states, one-hot
  typedef enum logic [5:0] {
    ST_SELFTEST = 6'h01,
    ST_FAULT = 6'h02,
    ST_IDLE = 6'h04,
    ST_ENABLE_BUTTONS = 6'h08,
    ST_DISCHARGE = 6'h10,
    ST_LOCKED = 6'h20
  } sup_state_type;

  typedef struct packed {
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
  } sync_regs_type;

  typedef struct packed {
    logic [31:0] cnt;
    logic [2:0] left;
    logic on;
  } beep_regs_type;
endpackage
`default_nettype wire

/* hdl/hv_supervisor.sv */
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module hv_supervisor
  import hv_pkg::*;
#(
  parameter int unsigned WDOG_CYC_P = `WDOG_CYC,
  parameter int unsigned BEEP_CYC_P = `BEEP_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic limit_view_i,
  input wire logic [1:0] enable_buttons_i,
  input wire logic disable_switch_i,
  input wire logic volt_knob_min_i,
  input wire logic module_ident_ok_i,
  input wire logic overvolt_fault_i,
  input wire logic overcur_fault_i,
  input wire logic thermal_fault_i,
  input wire logic load_arc_detect_i,
  input wire logic [`VOLT_W-1:0] meas_volts_i,
  input wire logic [`CURR_W-1:0] meas_curr_i,
  input wire logic [`RES_W-1:0] meas_res_i,
  input wire logic [`VOLT_W-1:0] limit_volts_i,
  input wire logic [`CURR_W-1:0] limit_curr_i,
  input wire logic res_giga_i,
  input wire logic curr_micro_i,
  output logic [`VOLT_W-1:0] volt_disp_o,
  output logic [`CURR_W-1:0] curr_disp_o,
  output logic [`RES_W-1:0] res_disp_o,
  output logic res_blank_o,
  output logic res_err_show_o,
  output logic hv_enable_o,
  output logic hazard_flasher_o,
  output logic supply_idle_lamp_o,
  output logic command_ready_lamp_o,
  output logic overvolt_lamp_o,
  output logic overcur_lamp_o,
  output logic thermal_lamp_o,
  output logic load_arc_lamp_o,
  output logic volt_limit_lamp_o,
  output logic curr_limit_lamp_o,
  output logic megohm_lamp_o,
  output logic gigohm_lamp_o,
  output logic milliamp_lamp_o,
  output logic microamp_lamp_o,
  output logic alarm_o
);
  // whole state of the block, outputs included
  typedef struct packed {
    sup_state_type st;
    logic [2:0] self_code; // software self-check result
    logic self_done; // software finished self-checks
    logic trip; // a latching trip caused the discharge
    logic arc; // load arc seen, held until power cycle
    logic [`VOLT_W-1:0] arc_volts; // specimen volts just before the arc
    logic [`VOLT_W-1:0] prev_volts; // last sample, source of arc capture
    logic [31:0] wdog; // cycles since last refresh
    logic [3:0] err;
    logic both_prev; // both buttons seen last cycle
    logic beep_req;
    logic [1:0] beep_cnt;
    logic aw_ok;
    logic w_ok;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [`VOLT_W-1:0] volt_disp;
    logic [`CURR_W-1:0] curr_disp;
    logic [`RES_W-1:0] res_disp;
    logic res_blank;
    logic hv_en;
    logic flasher;
    logic ready_lamp;
    logic ov_lamp;
    logic oc_lamp;
    logic th_lamp;
    logic arc_lamp;
    logic vlim_lamp;
    logic alarm;
    logic idle_lamp; // kept as its own flop so no gate sits after it
    logic err_show; // readout holds an error code
    logic clim_lamp; // current limit lamp, complement of the voltage lamp
    logic [3:0] range_lamps; // gigohm, megohm, microamp, milliamp
  } sup_regs_type;

  sup_regs_type cur_reg;
  sup_regs_type cur_next;
  logic [`SYNC_W-1:0] pins_s; // synchronised pins
  logic view_lim;
  logic both_btn;
  logic dis_sw;
  logic knob_min;
  logic mod_ok;
  logic ov_f;
  logic oc_f;
  logic th_f;
  logic arc_f;

  beep_if beep ();

  // panel switch, module and fault pins cross in through two flops; measurements and range selects come in direct
  pin_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pins_i({limit_view_i, enable_buttons_i, disable_switch_i, volt_knob_min_i,
             module_ident_ok_i, overvolt_fault_i, overcur_fault_i, thermal_fault_i,
             load_arc_detect_i}),
    .pins_o(pins_s)
  );

  beep_gen #(.BEEP_CYC_P(BEEP_CYC_P)) u_beep (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .bus(beep)
  );

  assign view_lim = pins_s[9];
  assign both_btn = pins_s[8] & pins_s[7];
  assign dis_sw = pins_s[6];
  assign knob_min = pins_s[5];
  assign mod_ok = pins_s[4];
  assign ov_f = pins_s[3];
  assign oc_f = pins_s[2];
  assign th_f = pins_s[1];
  assign arc_f = pins_s[0];
  assign beep.req = cur_reg.beep_req;
  assign beep.count = cur_reg.beep_cnt;

  // supervisor, register bus and readout selection in one pass
  always_comb
  begin
    logic kick;
    logic trip_now;
    logic wr_fire;
    kick = 1'b0;
    wr_fire = 1'b0;
    trip_now = ov_f | oc_f | th_f | arc_f;
    cur_next = cur_reg;
    cur_next.beep_req = 1'b0;
    cur_next.prev_volts = meas_volts_i;
    cur_next.both_prev = both_btn;

    // write channel: address and data taken in either order
    if (s_axi_awvalid_i && cur_reg.awready)
    begin
      cur_next.aw_ok = 1'b1;
      cur_next.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && cur_reg.wready)
    begin
      cur_next.w_ok = 1'b1;
      cur_next.wdata = s_axi_wdata_i;
      cur_next.wstrb = s_axi_wstrb_i;
    end
    wr_fire = cur_reg.aw_ok && cur_reg.w_ok && !cur_reg.bvalid;
    if (wr_fire)
    begin
      cur_next.aw_ok = 1'b0;
      cur_next.w_ok = 1'b0;
      cur_next.bvalid = 1'b1;
      cur_next.bresp = `RESP_OKAY;
      case (cur_reg.awaddr)
        `ADDR_CTRL:
          kick = cur_reg.wstrb[0] & cur_reg.wdata[`CTRL_KICK_BIT];
        `ADDR_SELFTEST:
        begin
          if (cur_reg.wstrb[0])
            cur_next.self_code = cur_reg.wdata[2:0];
          if (cur_reg.wstrb[1])
            cur_next.self_done = cur_reg.wdata[`SELF_DONE_BIT];
        end
        `ADDR_STATUS, `ADDR_ARC_VOLTS: ; // read-only, write ignored
        default:
          cur_next.bresp = `RESP_SLVERR;
      endcase
    end
    else if (cur_reg.bvalid && s_axi_bready_i)
      cur_next.bvalid = 1'b0;
    cur_next.awready = !cur_next.aw_ok && !cur_next.bvalid;
    cur_next.wready = !cur_next.w_ok && !cur_next.bvalid;

    // read channel: one outstanding read, answered the next cycle
    if (s_axi_arvalid_i && cur_reg.arready)
    begin
      cur_next.rvalid = 1'b1;
      cur_next.rresp = `RESP_OKAY;
      case (s_axi_araddr_i)
        `ADDR_CTRL: cur_next.rdata = 32'h0000_0000;
        `ADDR_SELFTEST:
          cur_next.rdata = 32'({cur_reg.self_done, 5'h00, cur_reg.self_code});
        `ADDR_STATUS:
          cur_next.rdata = 32'({cur_reg.arc, cur_reg.trip, cur_reg.err, 2'h0, cur_reg.st});
        `ADDR_ARC_VOLTS: cur_next.rdata = 32'(cur_reg.arc_volts);
        default:
        begin
          cur_next.rdata = 32'h0000_0000;
          cur_next.rresp = `RESP_SLVERR;
        end
      endcase
    end
    else if (cur_reg.rvalid && s_axi_rready_i)
      cur_next.rvalid = 1'b0;
    cur_next.arready = !cur_next.rvalid;

    // watchdog runs only while the supply is producing output
    if (cur_reg.st != ST_ENABLE_BUTTONS || kick)
      cur_next.wdog = 32'h0000_0000;
    else
      cur_next.wdog = cur_reg.wdog + 32'h0000_0001;

    // main sequence
    case (cur_reg.st)
      ST_SELFTEST:
        if (cur_reg.self_done)
        begin
          if (!mod_ok)
          begin
            cur_next.st = ST_FAULT;
            cur_next.err = `ERR_MOD_UNID;
            cur_next.beep_req = 1'b1;
            cur_next.beep_cnt = `BEEPS_FAULT;
          end
          else if (cur_reg.self_code >= `CPU_CODE_MIN)
          begin
            cur_next.st = ST_FAULT;
            cur_next.err = {1'b0, cur_reg.self_code};
            cur_next.beep_req = 1'b1;
            cur_next.beep_cnt = `BEEPS_FAULT;
          end
          else
            cur_next.st = ST_IDLE;
        end
      ST_FAULT:
        // locked until the cause is corrected
        if (mod_ok && cur_reg.self_code < `CPU_CODE_MIN)
        begin
          cur_next.st = ST_IDLE;
          cur_next.err = `ERR_NONE;
        end
      ST_IDLE, ST_ENABLE_BUTTONS:
        if (trip_now)
        begin
          // trip order picks the code shown when several fire at once
          cur_next.st = ST_DISCHARGE;
          cur_next.trip = 1'b1;
          cur_next.hv_en = 1'b0;
          cur_next.beep_req = 1'b1;
          cur_next.beep_cnt = `BEEPS_FAULT;
          cur_next.ov_lamp = ov_f;
          cur_next.oc_lamp = oc_f;
          cur_next.th_lamp = th_f;
          cur_next.arc_lamp = arc_f;
          if (arc_f)
          begin
            cur_next.arc = 1'b1;
            cur_next.arc_volts = cur_reg.prev_volts;
          end
          else if (th_f)
            cur_next.err = `ERR_THERMAL;
          else if (ov_f)
            cur_next.err = `ERR_OVERVOLT;
          else
            cur_next.err = `ERR_OVERCUR;
        end
        else if (cur_reg.st == ST_ENABLE_BUTTONS)
        begin
          // disable switch or missed refresh ends the test
          if (dis_sw || cur_reg.wdog >= 32'(WDOG_CYC_P - 1))
          begin
            cur_next.st = ST_DISCHARGE;
            cur_next.hv_en = 1'b0;
          end
        end
        else if (!mod_ok)
        begin
          cur_next.st = ST_FAULT;
          cur_next.err = `ERR_MOD_UNID;
          cur_next.beep_req = 1'b1;
          cur_next.beep_cnt = `BEEPS_FAULT;
        end
        else if (!dis_sw && both_btn && !cur_reg.both_prev && knob_min)
        begin
          cur_next.st = ST_ENABLE_BUTTONS;
          cur_next.hv_en = 1'b1;
          cur_next.beep_req = 1'b1;
          cur_next.beep_cnt = `BEEPS_ENABLE_BUTTONS;
        end
      ST_DISCHARGE:
        // all controls ignored until the specimen is safe
        if (meas_volts_i < `SAFE_VOLTS)
        begin
          cur_next.st = cur_reg.trip ? ST_LOCKED : ST_IDLE;
          if (cur_reg.arc)
          begin
            cur_next.err = `ERR_LOAD_ARC;
            cur_next.beep_req = 1'b1;
            cur_next.beep_cnt = `BEEPS_FAULT;
          end
        end
      ST_LOCKED: ; // only power removal leaves here
      default:
      begin
        cur_next.st = ST_LOCKED;
        cur_next.hv_en = 1'b0;
      end
    endcase

    // readouts
    if (cur_reg.st == ST_DISCHARGE)
      cur_next.volt_disp = meas_volts_i;
    else if (cur_reg.st == ST_LOCKED && cur_reg.arc)
      cur_next.volt_disp = cur_reg.arc_volts;
    else if (view_lim)
      cur_next.volt_disp = limit_volts_i;
    else
      cur_next.volt_disp = meas_volts_i;
    cur_next.curr_disp = view_lim ? limit_curr_i : meas_curr_i;
    cur_next.res_disp = (cur_next.err != `ERR_NONE) ? `RES_W'(cur_next.err) : meas_res_i;
    cur_next.res_blank = view_lim && cur_next.err == `ERR_NONE;
    // voltage lamp wins when at its limit, so one lamp is always lit
    cur_next.vlim_lamp = meas_volts_i >= limit_volts_i;
    cur_next.flasher = meas_volts_i > `SAFE_VOLTS || cur_next.hv_en;
    cur_next.ready_lamp = cur_next.st == ST_IDLE;
    cur_next.alarm = beep.sound;
    cur_next.idle_lamp = !cur_next.hv_en;
    cur_next.err_show = cur_next.err != `ERR_NONE;
    cur_next.clim_lamp = !cur_next.vlim_lamp;
    cur_next.range_lamps = {res_giga_i, !res_giga_i, curr_micro_i, !curr_micro_i};
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cur_reg <= '0;
      cur_reg.st <= ST_SELFTEST;
      cur_reg.self_code <= `SELFTEST_RST;
      cur_reg.idle_lamp <= 1'b1;
      cur_reg.clim_lamp <= 1'b1;
    end
    else
      cur_reg <= cur_next;
  end

  assign s_axi_awready_o = cur_reg.awready;
  assign s_axi_wready_o = cur_reg.wready;
  assign s_axi_bresp_o = cur_reg.bresp;
  assign s_axi_bvalid_o = cur_reg.bvalid;
  assign s_axi_arready_o = cur_reg.arready;
  assign s_axi_rdata_o = cur_reg.rdata;
  assign s_axi_rresp_o = cur_reg.rresp;
  assign s_axi_rvalid_o = cur_reg.rvalid;
  assign volt_disp_o = cur_reg.volt_disp;
  assign curr_disp_o = cur_reg.curr_disp;
  assign res_disp_o = cur_reg.res_disp;
  assign res_blank_o = cur_reg.res_blank;
  assign res_err_show_o = cur_reg.err_show;
  assign hv_enable_o = cur_reg.hv_en;
  assign hazard_flasher_o = cur_reg.flasher;
  assign supply_idle_lamp_o = cur_reg.idle_lamp;
  assign command_ready_lamp_o = cur_reg.ready_lamp;
  assign overvolt_lamp_o = cur_reg.ov_lamp;
  assign overcur_lamp_o = cur_reg.oc_lamp;
  assign thermal_lamp_o = cur_reg.th_lamp;
  assign load_arc_lamp_o = cur_reg.arc_lamp;
  assign volt_limit_lamp_o = cur_reg.vlim_lamp;
  assign curr_limit_lamp_o = cur_reg.clim_lamp;
  assign megohm_lamp_o = cur_reg.range_lamps[2];
  assign gigohm_lamp_o = cur_reg.range_lamps[3];
  assign milliamp_lamp_o = cur_reg.range_lamps[0];
  assign microamp_lamp_o = cur_reg.range_lamps[1];
  assign alarm_o = cur_reg.alarm;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_limit_view_volts: assert property ((view_lim && cur_reg.st == ST_IDLE)
    |=> volt_disp_o == $past(limit_volts_i)) else $error("limit view wrong volts");
  chk_live_view_curr: assert property (!view_lim
    |=> curr_disp_o == $past(meas_curr_i)) else $error("live view wrong current");
  chk_discharge_inhibit: assert property ((cur_reg.st == ST_DISCHARGE)
    |=> !hv_enable_o && volt_disp_o == $past(meas_volts_i)) else $error("discharge not inhibited");
  chk_trip_lockout: assert property ((cur_reg.st == ST_LOCKED)
    |=> cur_reg.st == ST_LOCKED && !hv_enable_o) else $error("lockout released");
  chk_one_limit_lamp: assert property (volt_limit_lamp_o != curr_limit_lamp_o)
    else $error("limit lamps not exclusive");
  chk_enable_cause: assert property ($rose(hv_enable_o)
    |-> $past(both_btn) && $past(knob_min) && !$past(dis_sw))
    else $error("supply on without cause");
  chk_disable_wins: assert property ((dis_sw && !(ov_f | oc_f | th_f | arc_f)
    && (cur_reg.st == ST_ENABLE_BUTTONS || cur_reg.st == ST_IDLE)) |=> !hv_enable_o)
    else $error("disable did not stop supply");
  chk_watchdog_stop: assert property ((cur_reg.st == ST_ENABLE_BUTTONS
    && cur_reg.wdog >= 32'(WDOG_CYC_P - 1)) |=> !hv_enable_o) else $error("watchdog late");
  chk_arc_signal: assert property ((arc_f && cur_reg.st == ST_ENABLE_BUTTONS)
    |=> load_arc_lamp_o && cur_reg.beep_req && cur_reg.st == ST_DISCHARGE && !hv_enable_o)
    else $error("arc not signalled");
  chk_arc_code: assert property ((cur_reg.st == ST_LOCKED && cur_reg.arc)
    |=> res_disp_o == `RES_W'(`ERR_LOAD_ARC) && volt_disp_o == cur_reg.arc_volts)
    else $error("arc code missing");

  cov_enable_buttons: cover property ($rose(hv_enable_o));
  cov_arc_lock: cover property (cur_reg.st == ST_LOCKED && cur_reg.arc);
  cov_wdog_stop: cover property (cur_reg.st == ST_ENABLE_BUTTONS && cur_reg.wdog >= 32'(WDOG_CYC_P - 1));

endmodule
`default_nettype wire

/* hdl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for the front panel switch, module and fault pins
module pin_sync
  import hv_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [`SYNC_W-1:0] pins_i,
  output logic [`SYNC_W-1:0] pins_o
);
  sync_regs_type cur_reg;
  sync_regs_type cur_next;

  // first stage feeds only the second stage
  always_comb
  begin
    cur_next.s1 = pins_i;
    cur_next.s2 = cur_reg.s1;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cur_reg <= '0;
    else
      cur_reg <= cur_next;
  end

  assign pins_o = cur_reg.s2;
endmodule
`default_nettype wire
